// File: design/eamd_decoder.sv
`timescale 1ns/1ns
// Functional notes
// - implicit-form opcodes consume no addressing bytes
// - 32-bit locator 100, form not 11: fetch sib
// - middle bits: opcode extension or register select
// - address size picks 16-bit or 32-bit table
// - 16-bit locators pick BX/BP/SI/DI combos, BP means SS
// - 16-bit forms: none, 8-bit, 16-bit; 00 110 direct
// - form 11, 16-bit data: byte or word register
// - form 11, 32-bit data: byte or dword register
// - 32-bit no sib: base from locator, EBP means SS
// - 32-bit 00 101: DS direct 32-bit displacement
// - form from first byte, scale/index/base from sib
// - scale 1,2,4,8; index 100 means none
// - sib base picks register, ESP/EBP mean SS
// - sib base 101, form 00: no base, 32-bit displacement plus any index, DS
// - sib base 101, forms 01/10: EBP plus displacement, SS
// - width bit: 8-bit or full operand size
module eamd_decoder (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic op_valid,
    output logic op_ready,
    input eamd_pkg::eamd_op_t op,
    input wire logic byte_valid,
    output logic byte_ready,
    input wire logic [7:0] byte_data,
    output logic res_valid,
    input wire logic res_ready,
    output eamd_pkg::eamd_res_t res
);

    eamd_pkg::eamd_state_t state_q;
    eamd_pkg::eamd_state_t state_d;
    eamd_pkg::eamd_op_t op_q;
    logic [7:0] modrm_q;
    logic [7:0] sib_q;
    logic [31:0] disp_q;
    logic [2:0] dcnt_q;
    eamd_pkg::eamd_res_t res_q;

    // state decode
    wire in_idle = (state_q == eamd_pkg::EAMD_ST_IDLE);
    wire in_modrm = (state_q == eamd_pkg::EAMD_ST_MODRM);
    wire in_sib = (state_q == eamd_pkg::EAMD_ST_SIB);
    wire in_disp = (state_q == eamd_pkg::EAMD_ST_DISP);
    wire in_load = (state_q == eamd_pkg::EAMD_ST_LOAD);
    wire in_done = (state_q == eamd_pkg::EAMD_ST_DONE);

    // handshakes
    wire wants_byte = in_modrm || in_sib || in_disp;
    wire op_take = op_valid && in_idle;
    wire byte_take = byte_valid && wants_byte;
    wire res_take = res_ready && in_done;

    assign op_ready = in_idle;
    assign byte_ready = wants_byte;
    assign res_valid = in_done;
    assign res = res_q;

    // live view of the addressing bytes: the byte on the bus while it
    // is being taken, else the stored copy, so the next step is known
    // in the same cycle the byte arrives
    wire [7:0] modrm_live = in_modrm ? byte_data : modrm_q;
    wire [7:0] sib_live = in_sib ? byte_data : sib_q;
    wire [1:0] mode = modrm_live[eamd_pkg::MODRM_MOD_LSB +: 2];
    wire [2:0] mid = modrm_live[eamd_pkg::MODRM_MID_LSB +: 3];
    wire [2:0] rm = modrm_live[eamd_pkg::MODRM_RM_LSB +: 3];

    // both tables decode in parallel; address size picks one
    eamd_pkg::eamd_ea_t ea16;
    eamd_pkg::eamd_ea_t ea32;

    eamd_ea16 u_ea16 (
        .mode(mode),
        .rm(rm),
        .ea(ea16)
    );

    eamd_ea32 u_ea32 (
        .mode(mode),
        .rm(rm),
        .sib(sib_live),
        .ea(ea32)
    );

    wire eamd_pkg::eamd_ea_t ea_sel = op_q.addr32 ? ea32 : ea16;

    // addressing-byte sequencing
    wire is_reg_form = (mode == eamd_pkg::MOD_REG);
    wire need_sib = op_q.addr32 && !is_reg_form && (rm == eamd_pkg::RM_SIB);

    logic [2:0] disp_len;
    always_comb begin
        case (ea_sel.dsz)
            eamd_pkg::EAMD_DSZ_8: disp_len = eamd_pkg::DLEN_8;
            eamd_pkg::EAMD_DSZ_16: disp_len = eamd_pkg::DLEN_16;
            eamd_pkg::EAMD_DSZ_32: disp_len = eamd_pkg::DLEN_32;
            default: disp_len = 3'h0;
        endcase
    end

    // a register form carries no displacement whatever the table says
    wire need_disp = !is_reg_form && (disp_len != 3'h0);
    wire disp_last = (dcnt_q == disp_len - 3'h1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            eamd_pkg::EAMD_ST_IDLE: begin
                if (op_take) begin
                    if (op.has_modrm) begin
                        state_d = eamd_pkg::EAMD_ST_MODRM;
                    end else begin
                        state_d = eamd_pkg::EAMD_ST_LOAD;
                    end
                end
            end
            eamd_pkg::EAMD_ST_MODRM: begin
                if (byte_take) begin
                    if (need_sib) begin
                        state_d = eamd_pkg::EAMD_ST_SIB;
                    end else if (need_disp) begin
                        state_d = eamd_pkg::EAMD_ST_DISP;
                    end else begin
                        state_d = eamd_pkg::EAMD_ST_LOAD;
                    end
                end
            end
            eamd_pkg::EAMD_ST_SIB: begin
                if (byte_take) begin
                    if (need_disp) begin
                        state_d = eamd_pkg::EAMD_ST_DISP;
                    end else begin
                        state_d = eamd_pkg::EAMD_ST_LOAD;
                    end
                end
            end
            eamd_pkg::EAMD_ST_DISP: begin
                if (byte_take && disp_last) begin
                    state_d = eamd_pkg::EAMD_ST_LOAD;
                end
            end
            eamd_pkg::EAMD_ST_LOAD: begin
                state_d = eamd_pkg::EAMD_ST_DONE;
            end
            eamd_pkg::EAMD_ST_DONE: begin
                if (res_take) begin
                    state_d = eamd_pkg::EAMD_ST_IDLE;
                end
            end
            default: begin
                state_d = eamd_pkg::EAMD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= eamd_pkg::EAMD_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // opcode attributes held for the whole instruction
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op_q <= '0;
        end else if (op_take) begin
            op_q <= op;
        end
    end

    // addressing bytes; cleared per instruction so an implicit form
    // never reports stale fields
    always_ff @(posedge ref_clk) begin
        if (reset || op_take) begin
            modrm_q <= 8'h00;
        end else if (in_modrm && byte_take) begin
            modrm_q <= byte_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || op_take) begin
            sib_q <= 8'h00;
        end else if (in_sib && byte_take) begin
            sib_q <= byte_data;
        end
    end

    // displacement bytes arrive low byte first
    wire [4:0] disp_pos = {dcnt_q[1:0], 3'h0};
    wire [31:0] disp_ins = 32'({24'h000000, byte_data} << disp_pos);
    wire [31:0] disp_mask = 32'(32'h0000_00ff << disp_pos);

    always_ff @(posedge ref_clk) begin
        if (reset || op_take) begin
            disp_q <= 32'h0000_0000;
            dcnt_q <= 3'h0;
        end else if (in_disp && byte_take) begin
            disp_q <= (disp_q & ~disp_mask) | disp_ins;
            dcnt_q <= dcnt_q + 3'h1;
        end
    end

    // displacement widened to the address width
    wire [7:0] disp_b = disp_q[7:0];
    wire [31:0] disp8_ext32 = {{24{disp_b[7]}}, disp_b};
    wire [31:0] disp8_ext16 = {16'h0000, {8{disp_b[7]}}, disp_b};
    wire [31:0] disp8_ext = op_q.addr32 ? disp8_ext32 : disp8_ext16;
    wire [31:0] disp16_ext = {16'h0000, disp_q[15:0]};

    logic [31:0] disp_final;
    always_comb begin
        case (ea_sel.dsz)
            eamd_pkg::EAMD_DSZ_8: disp_final = disp8_ext;
            eamd_pkg::EAMD_DSZ_16: disp_final = disp16_ext;
            eamd_pkg::EAMD_DSZ_32: disp_final = disp_q;
            default: disp_final = 32'h0000_0000;
        endcase
    end

    // operand size; byte registers share codes, AH..BH on 100..111
    wire eamd_pkg::eamd_osz_t osz_full =
        op_q.data32 ? eamd_pkg::EAMD_OSZ_32 : eamd_pkg::EAMD_OSZ_16;
    wire eamd_pkg::eamd_osz_t osz =
        op_q.w ? osz_full : eamd_pkg::EAMD_OSZ_8;

    // middle field meaning is fixed by the opcode, not by this byte
    wire mid_is_reg = op_q.has_modrm && !op_q.reg_is_ext;
    wire mid_is_ext = op_q.has_modrm && op_q.reg_is_ext;

    // memory form only with an addressing byte and form other than 11
    wire mem_form = op_q.has_modrm && !is_reg_form;
    wire eamd_pkg::eamd_ea_t ea_out = mem_form ? ea_sel : '0;

    eamd_pkg::eamd_res_t res_d;
    always_comb begin
        res_d = eamd_pkg::RES_RESET;
        res_d.implicit = !op_q.has_modrm;
        res_d.mem = mem_form;
        res_d.rm_reg = (op_q.has_modrm && is_reg_form) ? rm : 3'h0;
        res_d.osz = osz;
        res_d.reg_valid = mid_is_reg;
        res_d.opext_valid = mid_is_ext;
        res_d.mid = op_q.has_modrm ? mid : 3'h0;
        res_d.ea = ea_out;
        res_d.disp = mem_form ? disp_final : 32'h0000_0000;
        res_d.addr32 = op_q.addr32;
    end

    // result word stays put from the load until it is taken
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            res_q <= eamd_pkg::RES_RESET;
        end else if (in_load) begin
            res_q <= res_d;
        end
    end

endmodule // eamd_decoder

// File: design/eamd_pkg.sv
package eamd_pkg;

    // addressing-form field of the primary addressing byte
    localparam logic [1:0] MOD_NODISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISPW = 2'h2;
    localparam logic [1:0] MOD_REG = 2'h3;

    // field positions inside the addressing bytes
    localparam int MODRM_MOD_LSB = 6;
    localparam int MODRM_MID_LSB = 3;
    localparam int MODRM_RM_LSB = 0;
    localparam int SIB_SCALE_LSB = 6;
    localparam int SIB_INDEX_LSB = 3;
    localparam int SIB_BASE_LSB = 0;

    // special locator and sib codes
    localparam logic [2:0] RM_SIB = 3'h4;
    localparam logic [2:0] RM_DIRECT16 = 3'h6;
    localparam logic [2:0] RM_DIRECT32 = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h4;
    localparam logic [2:0] BASE_NOREG = 3'h5;

    // general register codes, same numbering in both widths
    localparam logic [2:0] GPR_BX = 3'h3;
    localparam logic [2:0] GPR_SP = 3'h4;
    localparam logic [2:0] GPR_BP = 3'h5;
    localparam logic [2:0] GPR_SI = 3'h6;
    localparam logic [2:0] GPR_DI = 3'h7;

    // segment codes in two-bit segment-register numbering
    localparam logic [1:0] SEG_SS = 2'h2;
    localparam logic [1:0] SEG_DS = 2'h3;

    // displacement byte counts
    localparam logic [2:0] DLEN_8 = 3'h1;
    localparam logic [2:0] DLEN_16 = 3'h2;
    localparam logic [2:0] DLEN_32 = 3'h4;

    typedef enum logic [1:0] {
        EAMD_DSZ_NONE = 2'h0,
        EAMD_DSZ_8 = 2'h1,
        EAMD_DSZ_16 = 2'h2,
        EAMD_DSZ_32 = 2'h3
    } eamd_dsz_t;

    typedef enum logic [1:0] {
        EAMD_OSZ_8 = 2'h0,
        EAMD_OSZ_16 = 2'h1,
        EAMD_OSZ_32 = 2'h2
    } eamd_osz_t;

    typedef enum logic [5:0] {
        EAMD_ST_IDLE = 6'h01,
        EAMD_ST_MODRM = 6'h02,
        EAMD_ST_SIB = 6'h04,
        EAMD_ST_DISP = 6'h08,
        EAMD_ST_LOAD = 6'h10,
        EAMD_ST_DONE = 6'h20
    } eamd_state_t;

    typedef struct packed {
        logic has_modrm;
        logic reg_is_ext;
        logic w;
        logic addr32;
        logic data32;
    } eamd_op_t;

    typedef struct packed {
        logic base_en;
        logic [2:0] base;
        logic index_en;
        logic [2:0] index;
        logic [1:0] scale;
        eamd_dsz_t dsz;
        logic [1:0] seg;
    } eamd_ea_t;

    typedef struct packed {
        logic implicit;
        logic mem;
        logic [2:0] rm_reg;
        eamd_osz_t osz;
        logic reg_valid;
        logic opext_valid;
        logic [2:0] mid;
        eamd_ea_t ea;
        logic [31:0] disp;
        logic addr32;
    } eamd_res_t;

    localparam eamd_res_t RES_RESET = '0;

endpackage

// File: design/eamd_ea16.sv
`timescale 1ns/1ns
module eamd_ea16 (
    input wire logic [1:0] mode,
    input wire logic [2:0] rm,
    output eamd_pkg::eamd_ea_t ea
);
    wire direct = (mode == eamd_pkg::MOD_NODISP) && (rm == eamd_pkg::RM_DIRECT16);
    // rm[2]=0 pairs BX/BP with SI/DI; rm[2]=1 picks one register alone
    wire base_en = !direct && (!rm[2] || rm[1]);
    wire index_en = !rm[2] || !rm[1];
    wire [2:0] base = rm[2] ? (rm[0] ? eamd_pkg::GPR_BX : eamd_pkg::GPR_BP)
                            : (rm[1] ? eamd_pkg::GPR_BP : eamd_pkg::GPR_BX);
    wire [2:0] index = rm[0] ? eamd_pkg::GPR_DI : eamd_pkg::GPR_SI;
    wire uses_bp = base_en && (base == eamd_pkg::GPR_BP);
    wire [1:0] seg = uses_bp ? eamd_pkg::SEG_SS : eamd_pkg::SEG_DS;
    wire eamd_pkg::eamd_dsz_t dsz =
        (mode == eamd_pkg::MOD_DISP8) ? eamd_pkg::EAMD_DSZ_8 :
        (mode == eamd_pkg::MOD_DISPW || direct) ? eamd_pkg::EAMD_DSZ_16 :
        eamd_pkg::EAMD_DSZ_NONE;

    assign ea = '{base_en: base_en, base: base, index_en: index_en, index: index,
                  scale: 2'h0, dsz: dsz, seg: seg};
endmodule // eamd_ea16

// File: design/eamd_ea32.sv
`timescale 1ns/1ns
module eamd_ea32 (
    input wire logic [1:0] mode,
    input wire logic [2:0] rm,
    input wire logic [7:0] sib,
    output eamd_pkg::eamd_ea_t ea
);
    wire has_sib = (rm == eamd_pkg::RM_SIB);
    wire [1:0] scale = sib[eamd_pkg::SIB_SCALE_LSB +: 2];
    wire [2:0] sidx = sib[eamd_pkg::SIB_INDEX_LSB +: 3];
    wire [2:0] sbase = sib[eamd_pkg::SIB_BASE_LSB +: 3];
    wire nodisp = (mode == eamd_pkg::MOD_NODISP);
    wire rm_direct = nodisp && (rm == eamd_pkg::RM_DIRECT32);
    wire sib_direct = nodisp && (sbase == eamd_pkg::BASE_NOREG);
    wire direct = has_sib ? sib_direct : rm_direct;
    wire [2:0] base = has_sib ? sbase : rm;
    wire base_en = !direct;
    // index code 100 means none; the scale is passed on untouched
    wire index_en = has_sib && (sidx != eamd_pkg::IDX_NONE);
    wire ss_base = (base == eamd_pkg::GPR_BP) || (has_sib && base == eamd_pkg::GPR_SP);
    wire [1:0] seg = (base_en && ss_base) ? eamd_pkg::SEG_SS : eamd_pkg::SEG_DS;
    wire eamd_pkg::eamd_dsz_t dsz =
        (mode == eamd_pkg::MOD_DISP8) ? eamd_pkg::EAMD_DSZ_8 :
        (mode == eamd_pkg::MOD_DISPW || direct) ? eamd_pkg::EAMD_DSZ_32 :
        eamd_pkg::EAMD_DSZ_NONE;

    assign ea = '{base_en: base_en, base: base, index_en: index_en, index: sidx,
                  scale: has_sib ? scale : 2'h0, dsz: dsz, seg: seg};
endmodule // eamd_ea32

// File: bench/eamd_decoder_properties.sv
`timescale 1ns/1ns
module eamd_decoder_properties (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic op_valid,
    input wire logic op_ready,
    input eamd_pkg::eamd_op_t op,
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire logic [7:0] byte_data,
    input wire logic res_valid,
    input wire logic res_ready,
    input eamd_pkg::eamd_res_t res
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    eamd_pkg::eamd_op_t op_q;
    logic [7:0] mrm_q;
    logic fb_q;
    logic tk;
    logic bt;
    assign tk = op_valid && op_ready;
    // first byte after an op is the addressing byte
    assign bt = byte_valid && byte_ready && fb_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op_q <= '0;
            mrm_q <= 8'h00;
            fb_q <= 1'b0;
        end else if (tk) begin
            op_q <= op;
            fb_q <= 1'b1;
        end else if (bt) begin
            mrm_q <= byte_data;
            fb_q <= 1'b0;
        end
    end
    a_implicit_no_bytes: assert property (tk && !op.has_modrm |=>
        !byte_ready && !op_ready ##1 (res_valid && !byte_ready && res.implicit))
        else $error("implicit form took bytes or answered late");
    a_sib_fetch: assert property (bt && op_q.addr32 && byte_data[2:0] == 3'h4 &&
        byte_data[7:6] != 2'h3 |=> byte_ready)
        else $error("second addressing byte not requested");
    a_no_extra16: assert property (bt && !op_q.addr32 && byte_data[7:6] == 2'h0 &&
        byte_data[2:0] != 3'h6 |=> !byte_ready ##1 res_valid)
        else $error("16-bit form without displacement took more bytes");
    a_reg_form: assert property (bt && byte_data[7:6] == 2'h3 |=>
        !byte_ready ##1 (res_valid && !res.mem && res.rm_reg == mrm_q[2:0]))
        else $error("register form wrong or took more bytes");
    a_mid_field: assert property (res_valid && !res.implicit |->
        res.mid == mrm_q[5:3] && res.opext_valid == op_q.reg_is_ext)
        else $error("middle field reported wrongly");
    a_table_pick: assert property (res_valid && !res.implicit |-> res.addr32 == op_q.addr32)
        else $error("address size of result differs from op");
    a_osz_sel: assert property (res_valid && !res.implicit |-> res.osz ==
        (!op_q.w ? eamd_pkg::EAMD_OSZ_8 : op_q.data32 ? eamd_pkg::EAMD_OSZ_32 : eamd_pkg::EAMD_OSZ_16))
        else $error("operand size wrong");
    a_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res))
        else $error("result changed before taken");
    a_disp_sext: assert property (res_valid && res.mem && mrm_q[7:6] == 2'h1 |->
        res.disp[31:8] == (res.addr32 ? {24{res.disp[7]}} : {16'h0000, {8{res.disp[7]}}}))
        else $error("byte displacement not sign extended");
endmodule // eamd_decoder_properties
bind eamd_decoder eamd_decoder_properties chk_u (.ref_clk(ref_clk), .reset(reset),
    .op_valid(op_valid), .op_ready(op_ready), .op(op), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data), .res_valid(res_valid),
    .res_ready(res_ready), .res(res));

// File: bench/eamd_fetch_model.sv
`timescale 1ns/1ns
module eamd_fetch_model (
    input wire logic clk,
    input wire logic ready,
    output logic valid,
    output logic [7:0] data
);
    logic [7:0] q[$];
    logic took;
    logic gap;
    logic stall;
    initial begin
        took = 1'b0;
        gap = 1'b0;
        stall = 1'b0;
        valid = 1'b0;
        data = 8'h00;
    end
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    always @(posedge clk) begin
        // sampled before the design's state moves on this edge
        took <= valid && ready;
    end
    // byte held until taken; idle data toggles so stale values never match
    always @(negedge clk) begin
        if (took) begin
            q.delete(0);
            gap = stall;
        end
        if (q.size() > 0 && !gap) begin
            valid = 1'b1;
            data = q[0];
        end else begin
            valid = 1'b0;
            data = ~data;
            gap = 1'b0;
        end
    end
endmodule // eamd_fetch_model

// File: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic ref_clk;
    logic reset;
    logic op_valid;
    logic op_ready;
    eamd_pkg::eamd_op_t op;
    logic byte_valid;
    logic byte_ready;
    logic [7:0] byte_data;
    logic res_valid;
    logic res_ready;
    eamd_pkg::eamd_res_t res;
    int bad_count = 0;
    int cmp_count = 0;
    eamd_decoder dut_u (.ref_clk(ref_clk), .reset(reset), .op_valid(op_valid),
        .op_ready(op_ready), .op(op), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .byte_data(byte_data), .res_valid(res_valid), .res_ready(res_ready), .res(res));
    eamd_fetch_model fm (.clk(ref_clk), .ready(byte_ready), .valid(byte_valid),
        .data(byte_data));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    function automatic logic [13:0] mask(input eamd_pkg::eamd_ea_t a);
        if (!a.base_en) a.base = 3'h0;
        if (!a.index_en) a.index = 3'h0;
        return a;
    endfunction
    task automatic xfer(input eamd_pkg::eamd_op_t o, output eamd_pkg::eamd_res_t r);
        int n;
        @(negedge ref_clk);
        op = o;
        op_valid = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
        n = 0;
        while (res_valid !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 50) begin
            bad_count++;
            end_sim();
        end
        // hold off one cycle so the result must stand
        @(negedge ref_clk);
        r = res;
        res_ready = 1'b1;
        @(negedge ref_clk);
        res_ready = 1'b0;
    endtask
    task automatic t_implicit();
        eamd_pkg::eamd_res_t r;
        // the queued byte must survive the implicit form untouched
        fm.push(8'h55);
        xfer(5'h07, r);
        check({r.implicit, r.mem}, 2'h2);
        check(fm.q.size(), 1);
        fm.push(8'h02);
        xfer(5'h13, r);
        check(r.mid, 3'h2);
        check(r.disp, 32'h0000_0002);
    endtask
    task automatic t_reg();
        eamd_pkg::eamd_op_t o;
        eamd_pkg::eamd_res_t r;
        eamd_pkg::eamd_osz_t z;
        for (int i = 0; i < 32; i++) begin
            o = {1'b1, i[1] ^ i[4], i[3], i[4], i[4]};
            fm.push({2'h3, ~i[2:0], i[2:0]});
            xfer(o, r);
            z = i[3] ? (i[4] ? eamd_pkg::EAMD_OSZ_32 : eamd_pkg::EAMD_OSZ_16) : eamd_pkg::EAMD_OSZ_8;
            check({r.mem, r.rm_reg}, {1'b0, i[2:0]});
            check(r.osz, z);
            check({r.reg_valid, r.opext_valid, r.mid}, {~o.reg_is_ext, o.reg_is_ext, ~i[2:0]});
        end
    endtask
    task automatic mem(input logic a, input logic [1:0] m, input logic [2:0] rm,
        input logic [7:0] sb);
        eamd_pkg::eamd_res_t r;
        eamd_pkg::eamd_ea_t e;
        logic [2:0] b;
        logic [7:0] d8;
        logic dw;
        fm.push({m, 3'h2, rm});
        b = (a && rm == 3'h4) ? sb[2:0] : rm;
        if (a && rm == 3'h4) fm.push(sb);
        d8 = rm[0] ? 8'h7f : 8'h90;
        dw = m == 2'h2 || m == 2'h0 && b == (a ? 3'h5 : 3'h6);
        if (m == 2'h1) fm.push(d8);
        if (dw) fm.push(8'h78);
        if (dw) fm.push(8'h56);
        if (dw && a) fm.push(8'h34);
        if (dw && a) fm.push(8'h12);
        xfer({3'h4, a, a}, r);
        e = '0;
        e.dsz = m == 2'h1 ? eamd_pkg::EAMD_DSZ_8 : !dw ? eamd_pkg::EAMD_DSZ_NONE :
            a ? eamd_pkg::EAMD_DSZ_32 : eamd_pkg::EAMD_DSZ_16;
        if (a) begin
            e.base_en = !(m == 2'h0 && b == 3'h5);
            e.base = b;
            e.index_en = rm == 3'h4 && sb[5:3] != 3'h4;
            e.index = sb[5:3];
            e.scale = rm == 3'h4 ? sb[7:6] : 2'h0;
            e.seg = e.base_en && b[2:1] == 2'h2 ? eamd_pkg::SEG_SS : eamd_pkg::SEG_DS;
        end else begin
            e.base_en = !rm[2] || rm == 3'h7 || rm == 3'h6 && m != 2'h0;
            e.base = (rm[2] ? rm[0] : !rm[1]) ? eamd_pkg::GPR_BX : eamd_pkg::GPR_BP;
            e.index_en = !rm[2] || !rm[1];
            e.index = rm[0] ? eamd_pkg::GPR_DI : eamd_pkg::GPR_SI;
            e.seg = e.base_en && e.base == eamd_pkg::GPR_BP ? eamd_pkg::SEG_SS : eamd_pkg::SEG_DS;
        end
        check(mask(r.ea), mask(e));
        check(r.disp, m == 2'h1 ? (a ? {{24{d8[7]}}, d8} : {16'h0000, {8{d8[7]}}, d8}) :
            !dw ? 32'h0 : a ? 32'h12345678 : 32'h00005678);
        check({r.mem, r.addr32}, {1'b1, a});
    endtask
    task automatic t_mem16();
        for (int i = 0; i < 24; i++) mem(1'b0, i[4:3], i[2:0], 8'h00);
    endtask
    task automatic t_mem32();
        for (int i = 0; i < 24; i++) if (i[2:0] != 3'h4) mem(1'b1, i[4:3], i[2:0], 8'h00);
    endtask
    task automatic t_sib();
        logic [2:0] x;
        fm.stall = 1'b1;
        for (int i = 0; i < 24; i++) begin
            x = ~i[2:0];
            // no index only with scale 00
            mem(1'b1, i[4:3], 3'h4, {x == 3'h4 ? 2'h0 : i[1:0], x, i[2:0]});
        end
        fm.stall = 1'b0;
    endtask
    initial begin
        reset = 1'b1;
        op_valid = 1'b0;
        op = '0;
        res_ready = 1'b0;
        repeat (4) @(negedge ref_clk);
        reset = 1'b0;
        t_implicit();
        t_reg();
        t_mem16();
        t_mem32();
        t_sib();
        end_sim();
    end
endmodule // testbench
